// file: rtl/gpt_timer.sv
// Gated period timer: 16-bit timer/counter with prescaler, gate and period match
//
// Behaviour
// - 16-bit counter compared with period register; match raises the interrupt flag.
// - Gated operation: flag raised on gate falling edge instead of match.
// - Modes: internal timer, synchronous external counter, asynchronous external counter.
// - Counter serves as real-time clock time base or free-running interval timer.
// - Counting continues while the processor idles or sleeps.
// - Count clock divided by ratio chosen with two-bit prescale select.
// - Source select bit, two-bit external select, gate enable choose counting.
// - Sync select decides synchronized or asynchronous counting of external clock.
// - Request forwarded only when enabled, with programmed three-bit priority.
`timescale 1ns/1ps
`default_nettype none
module gpt_timer
    import gpt_pkg::*;
(
    input  wire logic                          clk,
    input  wire logic                          reset,
    input  wire logic                          run_enable,
    input  wire logic [gpt_pkg::SEL_WIDTH-1:0] prescale_select,
    input  wire logic                          clock_source_select,
    input  wire logic [gpt_pkg::SEL_WIDTH-1:0] external_clock_select,
    input  wire logic                          gate_accumulate_enable,
    input  wire logic                          external_sync_select,
    input  wire logic [gpt_pkg::COUNT_WIDTH-1:0] period_register,
    input  wire logic                          period_irq_enable,
    input  wire logic [gpt_pkg::PRIO_WIDTH-1:0] period_irq_priority,
    input  wire logic                          irq_flag_clear,
    input  wire logic [gpt_pkg::EXT_SOURCES-1:0] ext_clock_pins,
    input  wire logic                          gate_pin,
    output logic [gpt_pkg::COUNT_WIDTH-1:0]    count_value,
    output logic                               irq_flag,
    output logic                               irq_request,
    output logic [gpt_pkg::PRIO_WIDTH-1:0]     irq_priority,
    output logic                               rtc_tick
);
    import gpt_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // Pin synchronisers
    logic [EXT_SOURCES-1:0] ext_meta_reg;
    logic [EXT_SOURCES-1:0] ext_sync_reg;
    logic                   ext_align_reg;
    logic                   ext_prev_reg;
    logic                   gate_meta_reg;
    logic                   gate_sync_reg;
    logic                   gate_prev_reg;

    always_ff @(posedge clk) begin
        if (reset) begin
            ext_meta_reg  <= '0;
            ext_sync_reg  <= '0;
            gate_meta_reg <= 1'b0;
            gate_sync_reg <= 1'b0;
        end else begin
            ext_meta_reg  <= ext_clock_pins;
            ext_sync_reg  <= ext_meta_reg;
            gate_meta_reg <= gate_pin;
            gate_sync_reg <= gate_meta_reg;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Source selection and edge detection
    gpt_src_t source;
    wire      ext_level;
    wire      ext_sampled;
    wire      ext_rise;
    wire      gate_fall;
    wire      gated_mode;
    wire      count_enable;
    wire      src_tick;
    logic     src_tick_c;

    assign source      = clock_source_select ? GPT_SRC_EXTERNAL
                                             : GPT_SRC_INTERNAL;
    assign ext_level   = ext_sync_reg[external_clock_select];
    // Synchronous mode adds one alignment stage; asynchronous mode
    // counts the edge as soon as it leaves the synchroniser
    assign ext_sampled = external_sync_select ? ext_align_reg : ext_level;
    assign ext_rise    = ext_sampled & ~ext_prev_reg;
    assign gated_mode  = gate_accumulate_enable & (source == GPT_SRC_INTERNAL);
    assign gate_fall   = gated_mode & run_enable & gate_prev_reg & ~gate_sync_reg;
    // Power state is not an input: counting never stops for idle or sleep
    assign count_enable = run_enable & (~gated_mode | gate_sync_reg);

    always_comb begin
        case (source)
            GPT_SRC_INTERNAL: src_tick_c = 1'b1;
            GPT_SRC_EXTERNAL: src_tick_c = ext_rise;
            default:          src_tick_c = 1'b0;
        endcase
    end
    assign src_tick = src_tick_c & count_enable;

    always_ff @(posedge clk) begin
        if (reset) begin
            ext_align_reg <= 1'b0;
            ext_prev_reg  <= 1'b0;
            gate_prev_reg <= 1'b0;
        end else begin
            ext_align_reg <= ext_level;
            ext_prev_reg  <= ext_sampled;
            gate_prev_reg <= gate_sync_reg;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Prescaler
    logic [PRESC_WIDTH-1:0] presc_reg;
    logic [PRESC_WIDTH-1:0] presc_next;
    logic [PRESC_WIDTH-1:0] presc_last;
    wire                    presc_wrap;
    wire                    count_tick;

    always_comb begin
        case (prescale_select)
            PRESC_SEL_DIV1:   presc_last = PRESC_LAST_DIV1;
            PRESC_SEL_DIV8:   presc_last = PRESC_LAST_DIV8;
            PRESC_SEL_DIV64:  presc_last = PRESC_LAST_DIV64;
            PRESC_SEL_DIV256: presc_last = PRESC_LAST_DIV256;
            default:          presc_last = PRESC_LAST_DIV1;
        endcase
    end

    // Prescaler only moves on source ticks, so a low gate holds it too
    assign presc_wrap = (presc_reg >= presc_last);
    assign count_tick = src_tick & presc_wrap;

    always_comb begin
        if (!run_enable) begin
            presc_next = PRESC_RESET;
        end else if (src_tick) begin
            presc_next = presc_wrap ? PRESC_RESET : presc_reg + PRESC_ONE;
        end else begin
            presc_next = presc_reg;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Counter and period match
    logic [COUNT_WIDTH-1:0] count_reg;
    logic [COUNT_WIDTH-1:0] count_next;
    logic [COUNT_WIDTH-1:0] count_inc;
    logic                   flag_reg;
    logic                   flag_next;
    logic                   tick_reg;
    logic                   tick_next;
    wire                    period_match;
    wire                    flag_set;
    wire                    flag_keep;

    assign period_match = count_tick & (count_reg == period_register);
    assign count_inc    = count_reg + COUNT_ONE;

    // Match wins over increment, so the interval is period plus one
    always_comb begin
        if (period_match) begin
            count_next = COUNT_RESET;
        end else if (count_tick) begin
            count_next = count_inc;
        end else begin
            count_next = count_reg;
        end
    end

    // Gate edge replaces the match as interrupt source
    assign flag_set  = gated_mode ? gate_fall : period_match;
    assign flag_keep = flag_reg & ~irq_flag_clear;
    // Set wins over a clear in the same cycle, so no event is lost
    assign flag_next = flag_set | flag_keep;
    assign tick_next = period_match;

    always_ff @(posedge clk) begin
        if (reset) begin
            presc_reg <= PRESC_RESET;
        end else begin
            presc_reg <= presc_next;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            count_reg <= COUNT_RESET;
        end else begin
            count_reg <= count_next;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            flag_reg <= 1'b0;
        end else begin
            flag_reg <= flag_next;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            tick_reg <= 1'b0;
        end else begin
            tick_reg <= tick_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Outputs
    // Priority is passed through untouched; ranking is left to the
    // interrupt controller outside this block
    assign count_value  = count_reg;
    assign irq_flag     = flag_reg;
    assign irq_request  = flag_reg & period_irq_enable;
    assign irq_priority = period_irq_priority;
    assign rtc_tick     = tick_reg;
endmodule : gpt_timer
`default_nettype wire

// file: rtl/gpt_pkg.sv
// Constants and types shared by the gated period timer
package gpt_pkg;
    localparam int COUNT_WIDTH   = 16;
    localparam int PRESC_WIDTH   = 8;
    localparam int SEL_WIDTH     = 2;
    localparam int PRIO_WIDTH    = 3;
    localparam int EXT_SOURCES   = 4;

    // Terminal values of the prescaler for ratios 1:1, 1:8, 1:64, 1:256
    localparam logic [PRESC_WIDTH-1:0] PRESC_LAST_DIV1   = 8'h00;
    localparam logic [PRESC_WIDTH-1:0] PRESC_LAST_DIV8   = 8'h07;
    localparam logic [PRESC_WIDTH-1:0] PRESC_LAST_DIV64  = 8'h3F;
    localparam logic [PRESC_WIDTH-1:0] PRESC_LAST_DIV256 = 8'hFF;

    localparam logic [SEL_WIDTH-1:0] PRESC_SEL_DIV1   = 2'h0;
    localparam logic [SEL_WIDTH-1:0] PRESC_SEL_DIV8   = 2'h1;
    localparam logic [SEL_WIDTH-1:0] PRESC_SEL_DIV64  = 2'h2;
    localparam logic [SEL_WIDTH-1:0] PRESC_SEL_DIV256 = 2'h3;

    localparam logic [COUNT_WIDTH-1:0] COUNT_RESET    = 16'h0000;
    localparam logic [PRESC_WIDTH-1:0] PRESC_RESET    = 8'h00;
    localparam logic [COUNT_WIDTH-1:0] COUNT_ONE      = 16'h0001;
    localparam logic [PRESC_WIDTH-1:0] PRESC_ONE      = 8'h01;

    // Count clock source
    typedef enum logic [1:0] {
        GPT_SRC_INTERNAL = 2'b01,
        GPT_SRC_EXTERNAL = 2'b10
    } gpt_src_t;
endpackage : gpt_pkg

// file: rtl/_unused_placeholder_removed.sv
// Intentionally empty design unit list
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

// file: verif/gpt_props_properties.sv
// Port assertions for the gated period timer
`timescale 1ns/1ps
`default_nettype none
module gpt_props (
    input wire logic clk, reset, run_enable, clock_source_select, gate_accumulate_enable,
    input wire logic irq_flag_clear, gate_pin, irq_flag, irq_request, period_irq_enable,
    input wire logic rtc_tick,
    input wire logic [1:0] prescale_select,
    input wire logic [2:0] irq_priority, period_irq_priority,
    input wire logic [15:0] count_value, period_register
);
    default clocking @(posedge clk); endclocking
    default disable iff (reset);
    wire plain = run_enable && !clock_source_select && !gate_accumulate_enable
        && prescale_select == 2'h0;
    wire gated = run_enable && gate_accumulate_enable && !clock_source_select;
    property p_req; irq_request == (irq_flag && period_irq_enable)
        && irq_priority == period_irq_priority; endproperty
    a_req: assert property (p_req) else $error("irq outputs wrong");
    property p_hold; !run_enable |=> $stable(count_value); endproperty
    a_hold: assert property (p_hold) else $error("count moved");
    property p_inc; plain && count_value != period_register
        |=> count_value == $past(count_value) + 16'h0001; endproperty
    a_inc: assert property (p_inc) else $error("no increment");
    property p_wrap; plain && count_value == period_register
        |=> count_value == 16'h0000 && irq_flag && rtc_tick; endproperty
    a_wrap: assert property (p_wrap) else $error("bad match");
    property p_gflag; gated && $fell(gate_pin) |-> ##[2:4] irq_flag; endproperty
    a_gflag: assert property (p_gflag) else $error("no gate flag");
    property p_ghold; (gated && !gate_pin) [*3] |=> $stable(count_value); endproperty
    a_ghold: assert property (p_ghold) else $error("gate ignored");
    property p_nomatch; (gated && gate_pin && !irq_flag) [*4] |=> !irq_flag; endproperty
    a_nomatch: assert property (p_nomatch) else $error("match flag gated");
    property p_stick; irq_flag && !irq_flag_clear |=> irq_flag; endproperty
    a_stick: assert property (p_stick) else $error("flag lost");
    cover property (plain && count_value == period_register);
    cover property (gated && $fell(gate_pin));
    cover property (rtc_tick);
endmodule : gpt_props
bind gpt_timer gpt_props gpt_props_i (.*);
`default_nettype wire

// file: verif/gpt_ext_src.sv
// External clock and gate source model
`timescale 1ns/1ps
`default_nettype none
module gpt_ext_src (
    input  wire logic       clk,
    input  wire logic [1:0] sel,
    output logic [3:0]      pins,
    output logic            gate
);
    logic lvl = 1'b0;
    logic [3:0] nz = 4'h5;
    // Unselected pins never rest, so a wrong select shows
    always @(posedge clk) nz <= ~nz;
    assign pins = (nz & ~(4'h1 << sel)) | ({3'h0, lvl} << sel);
    initial gate = 1'b0;
    task automatic pulse(input int n);
        repeat (2 * n) begin
            repeat (4) @(posedge clk);
            lvl <= ~lvl;
        end
    endtask : pulse
    task automatic hold_gate(input int n);
        gate <= 1'b1;
        repeat (n) @(posedge clk);
        gate <= 1'b0;
    endtask : hold_gate
endmodule : gpt_ext_src
`default_nettype wire

// file: verif/tb_gated_period_timer.sv
// Self-checking bench for the gated period timer
`timescale 1ns/1ps
`default_nettype none
module tb_gated_period_timer;
    import gpt_pkg::*;
    logic clk = 1'b0, reset = 1'b1, run_enable = 1'b0, clock_source_select = 1'b0, f;
    logic gate_accumulate_enable = 1'b0, external_sync_select = 1'b0, irq_flag_clear = 1'b0;
    logic period_irq_enable = 1'b0, irq_flag, irq_request, rtc_tick, gate_pin;
    logic [1:0] prescale_select = 2'h0, external_clock_select = 2'h0;
    logic [2:0] period_irq_priority = 3'h0, irq_priority;
    logic [3:0] ext_clock_pins;
    logic [15:0] period_register = 16'h0000, count_value;
    logic [31:0] seed = 32'h0001_639B;
    int n_mismatch = 0, compares = 0, n, p, m = 0;
    int div[4] = '{1, 8, 64, 256};
    gpt_timer gpt_timer_i (.*);
    gpt_ext_src gpt_ext_src_i (.clk, .sel(external_clock_select), .pins(ext_clock_pins),
        .gate(gate_pin));
    initial forever #4 clk = ~clk;
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        compares++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task automatic finish_test;
        $display("compares %0d mismatches %0d", compares, n_mismatch);
        if (n_mismatch == 0 && compares > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : finish_test
    // Stopped while configuring, so the prescaler starts from zero
    task automatic setup(input logic src, input logic gt, input logic [1:0] ps, int pr);
        @(posedge clk);
        {clock_source_select, gate_accumulate_enable} <= {src, gt};
        {prescale_select, period_register} <= {ps, 16'(pr)};
        irq_flag_clear <= 1'b1;
        @(posedge clk) irq_flag_clear <= 1'b0;
        @(posedge clk) run_enable <= 1'b1;
    endtask : setup
    task automatic done(input int t, input int pr, input logic gt);
        run_enable <= 1'b0;
        repeat (2) @(posedge clk);
        f = 1'b0;
        repeat (t) begin
            f = f | (m == pr);
            m = (m == pr) ? 0 : (m + 1) % 65536;
        end
        chk(count_value, 16'(m));
        chk(irq_flag, gt ? 1'b1 : f);
    endtask : done
    initial begin
        repeat (3) @(posedge clk);
        reset <= 1'b0;
        @(posedge clk);
        chk(count_value, 16'h0000);
        for (int i = 0; i < 8; i++) begin
            seed = lfsr(seed);
            {n, p} = {100 + seed[8:0], 27'h0, seed[13:9]};
            {period_irq_enable, period_irq_priority} <= seed[17:14];
            setup(1'b0, 1'b0, i[1:0], p);
            repeat (n) @(posedge clk);
            done(n / div[i % 4], p, 1'b0);
            chk(irq_request, seed[17] && f);
            chk(irq_priority, seed[16:14]);
        end
        $display("internal timer done");
        for (int s = 0; s < 8; s++) begin
            seed = lfsr(seed);
            {external_clock_select, external_sync_select} <= s[2:0];
            repeat (4) @(posedge clk);
            setup(1'b1, 1'b0, 2'h0, 65535);
            gpt_ext_src_i.pulse(2 + seed[2:0]);
            repeat (8) @(posedge clk);
            done(2 + seed[2:0], 65535, 1'b0);
        end
        $display("external counter done");
        p = (m + 3) % 65536;
        setup(1'b0, 1'b1, 2'h0, p);
        gpt_ext_src_i.hold_gate(10);
        chk(irq_flag, 1'b0);
        repeat (6) @(posedge clk);
        done(10, p, 1'b1);
        $display("gated mode done");
        finish_test();
    end
    initial begin
        repeat (20000) @(posedge clk);
        n_mismatch++;
        finish_test();
    end
endmodule : tb_gated_period_timer
`default_nettype wire
